// ===== src/acst_axis.sv
`timescale 1ns/100ps
`default_nettype none
module acst_axis
	import acst_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// sample streams
	input  wire logic [11:0] filt_in,
	input  wire logic        filt_valid,
	input  wire logic [11:0] unfilt_in,
	input  wire logic        unfilt_valid,
	// control
	input  wire logic        slow_enable,
	input  wire logic        corner_10hz,
	input  wire logic [1:0]  target_code,
	input  wire logic        fast_start,
	input  wire logic        load_valid,
	input  wire logic [7:0]  load_value,
	// status and results
	output logic [7:0]       comp_value,
	output logic             fast_busy,
	output logic [11:0]      filt_out,
	output logic             filt_out_valid,
	output logic [11:0]      unfilt_out,
	output logic             unfilt_out_valid
);
	acst_fast_type state;
	acst_fast_type next_state;
	logic [11:0] offset;
	logic [11:0] next_offset;
	logic [15:0] acc;
	logic [15:0] next_acc;
	logic [3:0]  count;
	logic [3:0]  next_count;
	logic [7:0]  next_comp_value;
	logic [11:0] next_filt_out;
	logic [11:0] next_unfilt_out;

	function automatic logic [13:0] sx14(input logic [11:0] v);
		return {{2{v[11]}}, v};
	endfunction

	function automatic logic [11:0] sat12(input logic [13:0] v);
		if (!v[13] && v[12:11] != 2'h0)
			return 12'h7ff;
		else if (v[13] && v[12:11] != 2'h3)
			return 12'h800;
		else
			return v[11:0];
	endfunction

	logic [13:0] sum_filt;
	logic [13:0] sum_unfilt;
	logic [15:0] acc_total;
	logic [11:0] target;
	logic [13:0] hp_step;

	always_comb begin
		sum_filt   = sx14(filt_in) + sx14(offset);
		sum_unfilt = sx14(unfilt_in) + sx14(offset);
		acc_total  = acc + {{4{filt_in[11]}}, filt_in};
		unique case (target_code)
			2'h1: target = ACST_TARGET_PLUS_1G;
			2'h2: target = ACST_TARGET_MINUS_1G;
			default: target = ACST_TARGET_ZERO;
		endcase
		// arithmetic shift keeps the step's sign
		if (corner_10hz)
			hp_step = $signed(sum_filt) >>> ACST_HP_SHIFT_10HZ;
		else
			hp_step = $signed(sum_filt) >>> ACST_HP_SHIFT_LOW;
		next_state      = state;
		next_offset     = offset;
		next_acc        = acc;
		next_count      = count;
		next_comp_value = comp_value;
		// correction reaches both streams, saturated
		next_filt_out   = filt_valid ? sat12(sum_filt) : filt_out;
		next_unfilt_out = unfilt_valid ? sat12(sum_unfilt) : unfilt_out;
		if (load_valid) begin
			next_comp_value = load_value;
			next_offset = {load_value, 4'h0};
		end else begin
			unique case (state)
				ACST_IDLE: begin
					if (fast_start) begin
						next_state = ACST_AVG;
						next_acc   = 16'h0000;
						next_count = 4'h0;
					end else if (slow_enable && filt_valid) begin
						next_offset = sat12(sx14(offset) - hp_step);
						next_comp_value = next_offset[11:ACST_WIDEN_SHIFT];
					end
				end
				ACST_AVG: begin
					if (filt_valid) begin
						next_acc   = acc_total;
						next_count = count + 4'h1;
						if (count == ACST_AVG_LAST) begin
							next_offset = sat12(sx14(target)
								- sx14(acc_total[15:ACST_AVG_SHIFT]));
							next_comp_value =
								next_offset[11:ACST_WIDEN_SHIFT];
							next_state = ACST_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state            <= ACST_IDLE;
			offset           <= ACST_WIDE_RESET;
			acc              <= 16'h0000;
			count            <= 4'h0;
			comp_value       <= ACST_REG_RESET;
			fast_busy        <= 1'b0;
			filt_out         <= ACST_WIDE_RESET;
			filt_out_valid   <= 1'b0;
			unfilt_out       <= ACST_WIDE_RESET;
			unfilt_out_valid <= 1'b0;
		end else begin
			state            <= next_state;
			offset           <= next_offset;
			acc              <= next_acc;
			count            <= next_count;
			comp_value       <= next_comp_value;
			fast_busy        <= (next_state == ACST_AVG);
			filt_out         <= next_filt_out;
			filt_out_valid   <= filt_valid;
			unfilt_out       <= next_unfilt_out;
			unfilt_out_valid <= unfilt_valid;
		end
	end
endmodule // acst_axis
`default_nettype wire

// ===== src/acst_pkg.sv
`default_nettype none
package acst_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] ACST_SELF_TEST_CONTROL_IDX      = 8'h32;
	localparam logic [7:0] ACST_COMPENSATION_CONTROL_IDX   = 8'h36;
	localparam logic [7:0] ACST_COMPENSATION_SETTINGS_IDX  = 8'h37;
	localparam logic [7:0] ACST_COMP_VALUE_X_IDX           = 8'h38;
	localparam logic [7:0] ACST_COMP_VALUE_Y_IDX           = 8'h39;
	localparam logic [7:0] ACST_COMP_VALUE_Z_IDX           = 8'h3a;
	// self_test_control fields
	localparam int ACST_ST_AXIS_LSB  = 0;
	localparam int ACST_ST_SIGN_BIT  = 2;
	localparam int ACST_ST_AMP_BIT   = 4;
	localparam logic [7:0] ACST_ST_WRITE_MASK = 8'h17;
	localparam logic [1:0] ACST_AXIS_NONE = 2'h0;
	localparam logic [1:0] ACST_AXIS_X    = 2'h1;
	localparam logic [1:0] ACST_AXIS_Y    = 2'h2;
	localparam logic [1:0] ACST_AXIS_Z    = 2'h3;
	// compensation_control fields
	localparam int ACST_CC_SLOW_X_BIT  = 0;
	localparam int ACST_CC_SLOW_Y_BIT  = 1;
	localparam int ACST_CC_SLOW_Z_BIT  = 2;
	localparam int ACST_CC_READY_BIT   = 4;
	localparam int ACST_CC_TRIG_LSB    = 5;
	localparam int ACST_CC_CLEAR_BIT   = 7;
	// compensation_settings fields
	localparam int ACST_CS_CORNER_BIT  = 0;
	localparam int ACST_CS_TARGET_X_LSB = 1;
	localparam int ACST_CS_TARGET_Y_LSB = 3;
	localparam int ACST_CS_TARGET_Z_LSB = 5;
	localparam logic [7:0] ACST_CS_WRITE_MASK = 8'h7f;
	// reset values
	localparam logic [7:0] ACST_REG_RESET   = 8'h00;
	localparam logic [11:0] ACST_WIDE_RESET = 12'h000;
	// fast compensation targets, 2g range: 1g is 1024 lsb
	localparam logic [11:0] ACST_TARGET_PLUS_1G  = 12'h400;
	localparam logic [11:0] ACST_TARGET_MINUS_1G = 12'hc00;
	localparam logic [11:0] ACST_TARGET_ZERO     = 12'h000;
	localparam logic [3:0]  ACST_AVG_LAST        = 4'hf;
	localparam int ACST_AVG_SHIFT = 4;
	// 8-bit register lsb equals 16 internal lsb
	localparam int ACST_WIDEN_SHIFT = 4;
	// high-pass step shifts for the two corner settings
	localparam int ACST_HP_SHIFT_10HZ  = 4;
	localparam int ACST_HP_SHIFT_LOW   = 8;
	// axi responses
	localparam logic [1:0] ACST_RESP_OKAY   = 2'h0;
	localparam logic [1:0] ACST_RESP_DECERR = 2'h3;
	typedef enum logic [0:0] {
		ACST_IDLE = 1'b0,
		ACST_AVG  = 1'b1
	} acst_fast_type;
endpackage
`default_nettype wire

// ===== src/acst_top.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module acst_top
	import acst_pkg::*;
#(
	parameter int ADDR_WIDTH = 8
) (
	// clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// axi4-lite write address
	input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input  wire logic [2:0]            s_axi_awprot,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// axi4-lite read address
	input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input  wire logic [2:0]            s_axi_arprot,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// nonvolatile image update
	input  wire logic                  image_load,
	input  wire logic [7:0]            image_x,
	input  wire logic [7:0]            image_y,
	input  wire logic [7:0]            image_z,
	// raw samples
	input  wire logic [11:0]           filt_x_in,
	input  wire logic [11:0]           filt_y_in,
	input  wire logic [11:0]           filt_z_in,
	input  wire logic                  filt_valid,
	input  wire logic [11:0]           unfilt_x_in,
	input  wire logic [11:0]           unfilt_y_in,
	input  wire logic [11:0]           unfilt_z_in,
	input  wire logic                  unfilt_valid,
	// compensated samples
	output logic [11:0]                filt_x_out,
	output logic [11:0]                filt_y_out,
	output logic [11:0]                filt_z_out,
	output logic                       filt_out_valid,
	output logic [11:0]                unfilt_x_out,
	output logic [11:0]                unfilt_y_out,
	output logic [11:0]                unfilt_z_out,
	output logic                       unfilt_out_valid,
	// self-test excitation
	output logic                       self_test_x_drive,
	output logic                       self_test_y_drive,
	output logic                       self_test_z_drive,
	output logic                       self_test_positive,
	output logic                       self_test_high_amp
);
	if (ADDR_WIDTH < 8) begin : g_bad_addr
		$error("acst_top: ADDR_WIDTH must be at least 8");
	end

	// bus state
	logic                  aw_full;
	logic                  next_aw_full;
	logic [ADDR_WIDTH-1:0] aw_addr;
	logic [ADDR_WIDTH-1:0] next_aw_addr;
	logic                  w_full;
	logic                  next_w_full;
	logic [7:0]            w_byte;
	logic [7:0]            next_w_byte;
	logic                  w_lane0;
	logic                  next_w_lane0;
	logic                  next_awready;
	logic                  next_wready;
	logic                  next_bvalid;
	logic [1:0]            next_bresp;
	logic                  next_arready;
	logic                  next_rvalid;
	logic [31:0]           next_rdata;
	logic [1:0]            next_rresp;
	// register state
	logic [7:0] st_ctrl;
	logic [7:0] next_st_ctrl;
	logic [2:0] slow_en;
	logic [2:0] next_slow_en;
	logic [7:0] settings;
	logic [7:0] next_settings;
	logic [1:0] trig;
	logic [1:0] next_trig;
	logic [2:0] start;
	logic [2:0] next_start;
	logic [2:0] load_valid;
	logic [2:0] next_load_valid;
	logic [7:0] load_value [3];
	logic [7:0] next_load_value [3];
	logic       next_st_x;
	logic       next_st_y;
	logic       next_st_z;
	// axis results
	logic [7:0]  comp_value [3];
	logic [2:0]  busy;
	logic [11:0] f_in [3];
	logic [11:0] u_in [3];
	logic [11:0] f_out [3];
	logic [11:0] u_out [3];
	logic [2:0]  f_vld;
	logic [2:0]  u_vld;
	logic [7:0]  image [3];
	logic        write_go;
	logic [7:0]  w_idx;
	logic [7:0]  r_idx;
	logic        w_hit;
	logic        r_hit;
	logic [7:0]  r_val;

	assign f_in  = '{filt_x_in, filt_y_in, filt_z_in};
	assign u_in  = '{unfilt_x_in, unfilt_y_in, unfilt_z_in};
	assign image = '{image_x, image_y, image_z};
	assign filt_x_out   = f_out[0];
	assign filt_y_out   = f_out[1];
	assign filt_z_out   = f_out[2];
	assign unfilt_x_out = u_out[0];
	assign unfilt_y_out = u_out[1];
	assign unfilt_z_out = u_out[2];
	assign filt_out_valid   = f_vld[0];
	assign unfilt_out_valid = u_vld[0];

	function automatic logic known(input logic [7:0] idx);
		return idx == ACST_SELF_TEST_CONTROL_IDX
			|| idx == ACST_COMPENSATION_CONTROL_IDX
			|| idx == ACST_COMPENSATION_SETTINGS_IDX
			|| idx == ACST_COMP_VALUE_X_IDX
			|| idx == ACST_COMP_VALUE_Y_IDX
			|| idx == ACST_COMP_VALUE_Z_IDX;
	endfunction

	always_comb begin
		w_idx = {2'h0, aw_addr[7:2]};
		r_idx = {2'h0, s_axi_araddr[7:2]};
		w_hit = known(w_idx) && aw_addr[1:0] == 2'h0
			&& aw_addr[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(aw_addr[7:2]);
		r_hit = known(r_idx) && s_axi_araddr[1:0] == 2'h0
			&& s_axi_araddr[ADDR_WIDTH-1:2]
			== (ADDR_WIDTH-2)'(s_axi_araddr[7:2]);
		unique case (r_idx)
			ACST_SELF_TEST_CONTROL_IDX: r_val = st_ctrl;
			// trigger and clear read as zero: both are write-only
			ACST_COMPENSATION_CONTROL_IDX:
				r_val = {3'h0, ~(|busy) && trig == ACST_AXIS_NONE,
					1'b0, slow_en};
			ACST_COMPENSATION_SETTINGS_IDX: r_val = settings;
			ACST_COMP_VALUE_X_IDX: r_val = comp_value[0];
			ACST_COMP_VALUE_Y_IDX: r_val = comp_value[1];
			ACST_COMP_VALUE_Z_IDX: r_val = comp_value[2];
			default: r_val = 8'h00;
		endcase
		write_go = aw_full && w_full && !s_axi_bvalid;
		// write channels are taken independently, response after both
		next_aw_full = aw_full;
		next_aw_addr = aw_addr;
		next_w_full  = w_full;
		next_w_byte  = w_byte;
		next_w_lane0 = w_lane0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_full = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_full  = 1'b1;
			next_w_byte  = s_axi_wdata[7:0];
			next_w_lane0 = s_axi_wstrb[0];
		end
		if (write_go) begin
			next_aw_full = 1'b0;
			next_w_full  = 1'b0;
		end
		next_awready = !next_aw_full;
		next_wready  = !next_w_full;
		next_bvalid  = s_axi_bvalid && !s_axi_bready;
		next_bresp   = s_axi_bresp;
		if (write_go) begin
			next_bvalid = 1'b1;
			next_bresp  = w_hit ? ACST_RESP_OKAY : ACST_RESP_DECERR;
		end
		// one read at a time; arready drops while the answer waits
		next_rvalid  = s_axi_rvalid;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready)
			next_rvalid  = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid  = 1'b1;
			next_rdata   = {24'h000000, r_val};
			next_rresp   = r_hit ? ACST_RESP_OKAY : ACST_RESP_DECERR;
		end
		// derived from rvalid so it opens right after reset release
		next_arready = !next_rvalid;
		// register effects
		next_st_ctrl  = st_ctrl;
		next_slow_en  = slow_en;
		next_settings = settings;
		next_trig     = (|start) ? ACST_AXIS_NONE : trig;
		next_start    = 3'h0;
		next_load_valid = 3'h0;
		for (int i = 0; i < 3; i++) begin
			next_load_value[i] = image[i];
			if (image_load)
				next_load_valid[i] = 1'b1;
		end
		if (write_go && w_hit && w_lane0) begin
			unique case (w_idx)
				ACST_SELF_TEST_CONTROL_IDX:
					next_st_ctrl = w_byte & ACST_ST_WRITE_MASK;
				ACST_COMPENSATION_CONTROL_IDX: begin
					next_slow_en = w_byte[2:0];
					next_trig = w_byte[ACST_CC_TRIG_LSB +: 2];
					if (next_trig != ACST_AXIS_NONE)
						next_start[next_trig - 2'h1] = 1'b1;
					if (w_byte[ACST_CC_CLEAR_BIT]) begin
						for (int i = 0; i < 3; i++) begin
							next_load_valid[i] = 1'b1;
							next_load_value[i] = 8'h00;
						end
					end
				end
				ACST_COMPENSATION_SETTINGS_IDX:
					next_settings = w_byte & ACST_CS_WRITE_MASK;
				default: begin
					// host writes overrule a same-cycle image update
					next_load_valid[w_idx[1:0]] = 1'b1;
					next_load_value[w_idx[1:0]] = w_byte;
				end
			endcase
		end
		next_st_x = st_ctrl[ACST_ST_AXIS_LSB +: 2] == ACST_AXIS_X;
		next_st_y = st_ctrl[ACST_ST_AXIS_LSB +: 2] == ACST_AXIS_Y;
		next_st_z = st_ctrl[ACST_ST_AXIS_LSB +: 2] == ACST_AXIS_Z;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full       <= 1'b0;
			aw_addr       <= '0;
			w_full        <= 1'b0;
			w_byte        <= 8'h00;
			w_lane0       <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= ACST_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= ACST_RESP_OKAY;
			st_ctrl       <= ACST_REG_RESET;
			slow_en       <= 3'h0;
			settings      <= ACST_REG_RESET;
			trig          <= ACST_AXIS_NONE;
			start         <= 3'h0;
			load_valid    <= 3'h0;
			load_value    <= '{default: 8'h00};
			self_test_x_drive  <= 1'b0;
			self_test_y_drive  <= 1'b0;
			self_test_z_drive  <= 1'b0;
			self_test_positive <= 1'b0;
			self_test_high_amp <= 1'b0;
		end else begin
			aw_full       <= next_aw_full;
			aw_addr       <= next_aw_addr;
			w_full        <= next_w_full;
			w_byte        <= next_w_byte;
			w_lane0       <= next_w_lane0;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
			st_ctrl       <= next_st_ctrl;
			slow_en       <= next_slow_en;
			settings      <= next_settings;
			trig          <= next_trig;
			start         <= next_start;
			load_valid    <= next_load_valid;
			load_value    <= next_load_value;
			self_test_x_drive  <= next_st_x;
			self_test_y_drive  <= next_st_y;
			self_test_z_drive  <= next_st_z;
			// sign and amplitude pass as written; force size is analog
			self_test_positive <= st_ctrl[ACST_ST_SIGN_BIT];
			self_test_high_amp <= st_ctrl[ACST_ST_AMP_BIT];
		end
	end

	for (genvar i = 0; i < 3; i++) begin : g_axis
		acst_axis u_axis (
			.aclk             (aclk),
			.aresetn          (aresetn),
			.filt_in          (f_in[i]),
			.filt_valid       (filt_valid),
			.unfilt_in        (u_in[i]),
			.unfilt_valid     (unfilt_valid),
			.slow_enable      (slow_en[i]),
			.corner_10hz      (settings[ACST_CS_CORNER_BIT]),
			.target_code      (settings[ACST_CS_TARGET_X_LSB + 2*i +: 2]),
			.fast_start       (start[i]),
			.load_valid       (load_valid[i]),
			.load_value       (load_value[i]),
			.comp_value       (comp_value[i]),
			.fast_busy        (busy[i]),
			.filt_out         (f_out[i]),
			.filt_out_valid   (f_vld[i]),
			.unfilt_out       (u_out[i]),
			.unfilt_out_valid (u_vld[i])
		);
	end
endmodule // acst_top
`default_nettype wire

// ===== test/acst_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module acst_top_monitor (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// sample strobes
	input wire logic        filt_valid,
	input wire logic        filt_out_valid,
	input wire logic        unfilt_valid,
	input wire logic        unfilt_out_valid,
	// excitation
	input wire logic        self_test_x_drive,
	input wire logic        self_test_y_drive,
	input wire logic        self_test_z_drive
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_st_one_axis: assert property ($onehot0({self_test_x_drive,
		self_test_y_drive, self_test_z_drive}))
		else $error("more than one axis excited");
	chk_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	chk_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped early");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read answer late");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready
		|-> ##[1:6] s_axi_bvalid)
		else $error("write answer missing");
	chk_rdata_upper: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_filt_delay: assert property (filt_valid |=> filt_out_valid)
		else $error("filtered output strobe missing");
	chk_unfilt_delay: assert property (unfilt_out_valid |->
		$past(unfilt_valid))
		else $error("unfiltered output strobe without input");
endmodule // acst_top_monitor
`default_nettype wire

// ===== test/acst_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module acst_top_tb;
	import acst_pkg::*;
	logic aclk = 1'h0, aresetn = 1'h0, image_load = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, filt_out_valid, unfilt_out_valid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [7:0] image_x = 8'h0, image_y = 8'h0, image_z = 8'h0;
	logic [11:0] filt_x_in = 12'h0, filt_y_in = 12'h0, filt_z_in = 12'h0;
	logic [11:0] unfilt_x_in = 12'h0, unfilt_y_in = 12'h0;
	logic [11:0] unfilt_z_in = 12'h0, s;
	logic filt_valid = 1'h0, unfilt_valid = 1'h0;
	logic [11:0] filt_x_out, filt_y_out, filt_z_out;
	logic [11:0] unfilt_x_out, unfilt_y_out, unfilt_z_out;
	logic self_test_x_drive, self_test_y_drive, self_test_z_drive;
	logic self_test_positive, self_test_high_amp;
	logic [7:0] ev [3];
	logic [1:0] fax [4] = '{2'h1, 2'h2, 2'h3, 2'h1};
	logic [1:0] fcd [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
	logic [11:0] fsm [4] = '{12'h010, 12'h7f0, 12'h7ff, 12'hff0};
	logic signed [11:0] off;
	int num_errors = 0, cmp_count = 0, i, k;

	acst_top #(.ADDR_WIDTH(8)) dut (.*);
	always #5 aclk = ~aclk;

	task automatic end_of_test;
		if (num_errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// bounded wait: a hung handshake ends the run
	task automatic tick(inout int n);
		@(posedge aclk);
		n++;
		if (n > 100) begin
			num_errors++;
			$display("BAD %0t bus wait ran out", $time);
			end_of_test;
		end
	endtask
	task automatic wr(input logic [7:0] ix, input logic [7:0] v,
			output logic [1:0] rs);
		int n;
		logic dn;
		n = 0;
		dn = 1'h0;
		s_axi_awaddr <= {ix[5:0], 2'h0};
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!dn) begin
			tick(n);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) begin
				rs = s_axi_bresp;
				s_axi_bready <= 1'h0;
				dn = 1'h1;
			end
		end
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] ix, output logic [31:0] dv,
			output logic [1:0] rs);
		int n;
		logic dn;
		n = 0;
		dn = 1'h0;
		s_axi_araddr <= {ix[5:0], 2'h0};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!dn) begin
			tick(n);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) begin
				dv = s_axi_rdata;
				rs = s_axi_rresp;
				s_axi_rready <= 1'h0;
				dn = 1'h1;
			end
		end
		@(posedge aclk);
	endtask
	task automatic rc(input logic [7:0] ix, input logic [7:0] e);
		rd(ix, d, r);
		chk(d, {24'h0, e});
		chk({30'h0, r}, {30'h0, ACST_RESP_OKAY});
	endtask
	function automatic logic [11:0] sat12(input logic [12:0] t);
		if (t[12] != t[11])
			return t[12] ? 12'h800 : 12'h7ff;
		return t[11:0];
	endfunction
	function automatic logic [11:0] comp(input logic [11:0] x,
			input logic [7:0] v);
		return sat12({x[11], x} + {v[7], v, 4'h0});
	endfunction
	function automatic logic [7:0] fexp(input logic [1:0] cd,
			input logic [11:0] x);
		logic [11:0] t;
		t = cd == 2'h1 ? ACST_TARGET_PLUS_1G :
			cd == 2'h2 ? ACST_TARGET_MINUS_1G : ACST_TARGET_ZERO;
		t = sat12({t[11], t} - {x[11], x});
		return t[11:4];
	endfunction
	// unfiltered stream gets the values rotated to tell streams apart
	task automatic smp(input logic [11:0] x, y, z, input logic c);
		{filt_x_in, filt_y_in, filt_z_in} <= {x, y, z};
		{unfilt_x_in, unfilt_y_in, unfilt_z_in} <= {y, z, x};
		filt_valid <= 1'h1;
		unfilt_valid <= 1'h1;
		@(posedge aclk);
		filt_valid <= 1'h0;
		unfilt_valid <= 1'h0;
		#1;
		if (c) begin
			chk(filt_x_out, comp(x, ev[0]));
			chk(filt_y_out, comp(y, ev[1]));
			chk(filt_z_out, comp(z, ev[2]));
			chk(unfilt_x_out, comp(y, ev[0]));
			chk(unfilt_y_out, comp(z, ev[1]));
			chk(unfilt_z_out, comp(x, ev[2]));
		end
		@(posedge aclk);
	endtask

	initial begin
		void'($urandom(32'ha66743fb));
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rc(ACST_SELF_TEST_CONTROL_IDX, 8'h00);
		rc(ACST_COMPENSATION_CONTROL_IDX, 8'h10);
		for (i = 0; i < 4; i++)
			rc(ACST_COMPENSATION_SETTINGS_IDX + 8'(i), 8'h00);
		rd(8'h30, d, r);
		chk(d, 32'h0);
		chk({30'h0, r}, {30'h0, ACST_RESP_DECERR});
		wr(8'h30, 8'hff, r);
		chk({30'h0, r}, {30'h0, ACST_RESP_DECERR});
		// every axis code with both signs, amplitude high
		for (i = 0; i < 8; i++) begin
			wr(ACST_SELF_TEST_CONTROL_IDX, {3'h0, 2'h2, i[2:0]}, r);
			repeat (2) @(posedge aclk);
			#1;
			chk({self_test_z_drive, self_test_y_drive, self_test_x_drive},
				32'h1 << i[1:0] >> 1);
			chk(self_test_positive, i[2]);
			chk(self_test_high_amp, 32'h1);
			rc(ACST_SELF_TEST_CONTROL_IDX, {3'h0, 2'h2, i[2:0]});
		end
		wr(ACST_SELF_TEST_CONTROL_IDX, 8'h00, r);
		// saturation corners first, then random; odd rounds by image
		for (k = 0; k < 6; k++) begin
			for (i = 0; i < 3; i++)
				ev[i] = k == 0 ? 8'h7f : k == 1 ? 8'h80 : 8'($urandom);
			if (k[0]) begin
				{image_x, image_y, image_z} <= {ev[0], ev[1], ev[2]};
				image_load <= 1'h1;
				@(posedge aclk);
				image_load <= 1'h0;
				repeat (3) @(posedge aclk);
			end else
				for (i = 0; i < 3; i++)
					wr(ACST_COMP_VALUE_X_IDX + 8'(i), ev[i], r);
			for (i = 0; i < 3; i++)
				rc(ACST_COMP_VALUE_X_IDX + 8'(i), ev[i]);
			s = k == 0 ? 12'h7ff : k == 1 ? 12'h800 : 12'($urandom);
			smp(s, s ^ 12'h0f0, ~s, 1'h1);
			smp(12'($urandom), 12'($urandom), 12'($urandom), 1'h1);
		end
		wr(ACST_COMPENSATION_CONTROL_IDX, 8'h80, r);
		for (i = 0; i < 3; i++)
			rc(ACST_COMP_VALUE_X_IDX + 8'(i), 8'h00);
		rc(ACST_COMPENSATION_CONTROL_IDX, 8'h10);
		// slow loop on x alone at the 10 Hz corner
		wr(ACST_COMPENSATION_SETTINGS_IDX, 8'h01, r);
		wr(ACST_COMPENSATION_CONTROL_IDX, 8'h01, r);
		rc(ACST_COMPENSATION_CONTROL_IDX, 8'h11);
		off = 12'sh000;
		for (i = 0; i < 5; i++) begin
			smp(12'h100, 12'h100, 12'h100, 1'h0);
			off = off - ((12'sh100 + off) >>> 4);
		end
		rc(ACST_COMP_VALUE_X_IDX, off[11:4]);
		rc(ACST_COMP_VALUE_Y_IDX, 8'h00);
		// slow loop on y alone at the low corner
		wr(ACST_COMPENSATION_SETTINGS_IDX, 8'h00, r);
		wr(ACST_COMPENSATION_CONTROL_IDX, 8'h02, r);
		off = 12'sh000;
		for (i = 0; i < 5; i++) begin
			smp(12'h7f0, 12'h7f0, 12'h7f0, 1'h0);
			off = off - ((12'sh7f0 + off) >>> 8);
		end
		rc(ACST_COMP_VALUE_Y_IDX, off[11:4]);
		wr(ACST_COMPENSATION_CONTROL_IDX, 8'h00, r);
		// one-shot runs; no value writes while a run is busy
		for (i = 0; i < 4; i++) begin
			wr(ACST_COMPENSATION_SETTINGS_IDX,
				8'(fcd[i]) << (2 * fax[i] - 1), r);
			wr(ACST_COMPENSATION_CONTROL_IDX, {1'h0, fax[i], 5'h00}, r);
			rc(ACST_COMPENSATION_CONTROL_IDX, 8'h00);
			repeat (16) smp(fsm[i], fsm[i], fsm[i], 1'h0);
			repeat (4) @(posedge aclk);
			rc(ACST_COMPENSATION_CONTROL_IDX, 8'h10);
			rc(ACST_COMP_VALUE_X_IDX + 8'(fax[i]) - 8'h01,
				fexp(fcd[i], fsm[i]));
		end
		end_of_test;
	end
endmodule // acst_top_tb

bind acst_top acst_top_monitor mon (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.filt_valid(filt_valid), .filt_out_valid(filt_out_valid),
	.unfilt_valid(unfilt_valid), .unfilt_out_valid(unfilt_out_valid),
	.self_test_x_drive(self_test_x_drive),
	.self_test_y_drive(self_test_y_drive),
	.self_test_z_drive(self_test_z_drive)
);
`default_nettype wire
